/* File: hdl/ust_pkg.sv */
package ust_pkg;

   // ==========================================================
   // Processor modes and request/answer carriers
   // ==========================================================
   typedef enum logic [1:0] {
      UST_MODE_USER,
      UST_MODE_SUPER,
      UST_MODE_KERNEL
   } ust_mode_t;

   typedef struct packed {
      logic [63:0] vaddr;
      ust_mode_t   mode;
      logic        fetch;
   } ust_req_t;

   typedef struct packed {
      logic [63:0] paddr;
      logic [2:0]  attr;
      logic        addr_err;
      logic        bypass;
      logic        probe;
   } ust_resp_t;

   // ==========================================================
   // Address windows
   // ==========================================================
   localparam logic [63:0] UST_CACHED_LOW_KERNEL_WINDOW_BASE  = 64'hFFFF_FFFF_8000_0000;
   localparam logic [63:0] UST_UNCACHED_LOW_KERNEL_WINDOW_BASE  = 64'hFFFF_FFFF_A000_0000;
   localparam logic [63:0] UST_PROBE_LO    = 64'hFFFF_FFFF_FF20_0000;
   localparam logic [63:0] UST_PROBE_HI    = 64'hFFFF_FFFF_FF3F_FFFF;
   localparam logic [1:0]  UST_XPHYS_QUAD  = 2'h2;
   localparam int          UST_WIN_LSB     = 29;
   localparam int          UST_ATTR_MSB    = 61;
   localparam int          UST_ATTR_LSB    = 59;
   localparam int          UST_XPHYS_TOP   = 58;
   localparam int          UST_SEXT_BIT    = 31;
   localparam logic [2:0]  UST_ATTR_UNCACH = 3'h2;

   // ==========================================================
   // Register map (byte addresses)
   // ==========================================================
   localparam logic [7:0] UST_REG_CFG     = 8'h00;
   localparam logic [7:0] UST_REG_IRQ_ST  = 8'h04;
   localparam logic [7:0] UST_REG_IRQ_MSK = 8'h08;
   localparam logic [7:0] UST_REG_PA_LO   = 8'h0C;
   localparam logic [7:0] UST_REG_PA_HI   = 8'h10;
   localparam logic [7:0] UST_REG_INFO    = 8'h14;

   // Configuration field positions
   localparam int UST_CFG_K0_LSB = 0;
   localparam int UST_CFG_ERL    = 3;
   localparam int UST_CFG_UX     = 4;
   localparam int UST_CFG_KX     = 5;
   localparam int UST_CFG_DM     = 6;
   localparam int UST_CFG_W      = 7;
   localparam logic [6:0] UST_CFG_RST = 7'h03;

   // Interrupt event positions
   localparam int UST_EV_ERR   = 0;
   localparam int UST_EV_PROBE = 1;
   localparam int UST_EV_XPHYS = 2;
   localparam int UST_EV_W     = 3;
   localparam logic [2:0] UST_IRQ_RST = 3'h0;

endpackage : ust_pkg

/* File: hdl/ust_translate.sv */
`timescale 1ns/1ps
module ust_translate #(
   parameter int PA_W         = 36,
   parameter int SEG_W        = 40,
   parameter bit PROBE_IMPL   = 1'b1,
   parameter bit ERL_KEEP_HI  = 1'b1,
   parameter bit ERL_WIDE     = 1'b1
) (
   input  wire logic           ref_clk_i,
   input  wire logic           rst_n_i,
   input  wire logic           req_valid_i,
   input  wire ust_pkg::ust_req_t req_i,
   output logic                rsp_valid_o,
   output ust_pkg::ust_resp_t  rsp_o,
   input  wire logic           wb_cyc_i,
   input  wire logic           wb_stb_i,
   input  wire logic           wb_we_i,
   input  wire logic [7:0]     wb_adr_i,
   input  wire logic [3:0]     wb_sel_i,
   input  wire logic [31:0]    wb_dat_i,
   output logic [31:0]         wb_dat_o,
   output logic                wb_ack_o,
   output logic                irq_o
);

   // ==========================================================
   // Configuration and status state
   // ==========================================================
   logic [ust_pkg::UST_CFG_W-1:0] cfg_q;
   logic [ust_pkg::UST_EV_W-1:0]  irq_st_q;
   logic [ust_pkg::UST_EV_W-1:0]  irq_msk_q;
   logic                          ack_q;
   logic [31:0]                   dat_q;
   logic                          rsp_valid_q;
   ust_pkg::ust_resp_t            rsp_q;

   logic [2:0] kernel_window_cache_attr;
   logic       error_level_bit;
   logic       user_wide_addr_enable;
   logic       kernel_wide_addr_enable;
   logic       debug_mode_flag;

   assign kernel_window_cache_attr =
      cfg_q[ust_pkg::UST_CFG_K0_LSB +: 3];
   assign error_level_bit         = cfg_q[ust_pkg::UST_CFG_ERL];
   assign user_wide_addr_enable   = cfg_q[ust_pkg::UST_CFG_UX];
   assign kernel_wide_addr_enable = cfg_q[ust_pkg::UST_CFG_KX];
   assign debug_mode_flag         = cfg_q[ust_pkg::UST_CFG_DM];

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic win_hit(input logic [63:0] a,
                                    input logic [63:0] base);
      win_hit = (a[63:ust_pkg::UST_WIN_LSB] ==
                 base[63:ust_pkg::UST_WIN_LSB]);
   endfunction : win_hit

   function automatic logic [63:0] low_mask(input int w);
      low_mask = (64'h1 << w) - 64'h1;
   endfunction : low_mask

   localparam logic [63:0] PA_MASK  = low_mask(PA_W);
   localparam logic [63:0] SEG_MASK = low_mask(SEG_W);
   localparam logic [63:0] W29_MASK = low_mask(ust_pkg::UST_WIN_LSB);
   localparam logic [63:0] W31_MASK = low_mask(ust_pkg::UST_SEXT_BIT);

   // ==========================================================
   // Effective address
   // ==========================================================
   logic [63:0] va;
   logic [63:0] ea;
   logic        is_user;
   logic        is_priv;

   assign va      = req_i.vaddr;
   assign is_user = (req_i.mode == ust_pkg::UST_MODE_USER);
   // Debug mode carries full kernel access
   assign is_priv = (req_i.mode == ust_pkg::UST_MODE_KERNEL) ||
                    debug_mode_flag;

   // Fetches keep their computed address
   always_comb begin
      if (is_user && !debug_mode_flag && !user_wide_addr_enable &&
          !req_i.fetch) begin
         ea = {{32{va[ust_pkg::UST_SEXT_BIT]}}, va[31:0]};
      end else begin
         // Privileged carry out of bit 31 passes through as is
         ea = va;
      end
   end

   // ==========================================================
   // Region decode
   // ==========================================================
   logic in_uncached_low_kernel_window;
   logic in_cached_low_kernel_window;
   logic in_xphys;
   logic in_probe;
   logic in_kuseg;
   logic in_xkuseg;
   logic xphys_hi_err;

   assign in_uncached_low_kernel_window = win_hit(ea, ust_pkg::UST_UNCACHED_LOW_KERNEL_WINDOW_BASE);
   assign in_cached_low_kernel_window = win_hit(ea, ust_pkg::UST_CACHED_LOW_KERNEL_WINDOW_BASE);
   assign in_xphys = (ea[63:62] == ust_pkg::UST_XPHYS_QUAD);
   // Exact bounds, not the whole top kernel segment
   assign in_probe = PROBE_IMPL &&
                     (ea >= ust_pkg::UST_PROBE_LO) &&
                     (ea <= ust_pkg::UST_PROBE_HI);
   assign in_kuseg  = (ea[63:31] == 33'h0_0000_0000);
   assign in_xkuseg = !in_kuseg && ((ea & ~SEG_MASK) == 64'h0);
   assign xphys_hi_err =
      |(ea[ust_pkg::UST_XPHYS_TOP:0] &
        ~PA_MASK[ust_pkg::UST_XPHYS_TOP:0]);

   // ==========================================================
   // Translation
   // ==========================================================
   ust_pkg::ust_resp_t xl;

   always_comb begin
      xl          = '0;
      xl.paddr    = 64'h0;
      xl.attr     = 3'h0;
      xl.addr_err = 1'b0;
      xl.bypass   = 1'b0;
      xl.probe    = 1'b0;
      if (in_probe && debug_mode_flag) begin
         xl.bypass = 1'b1;
         xl.probe  = 1'b1;
         xl.paddr  = ea & PA_MASK;
         xl.attr   = ust_pkg::UST_ATTR_UNCACH;
      end else if (in_uncached_low_kernel_window) begin
         xl.addr_err = !is_priv;
         xl.bypass   = is_priv;
         xl.paddr    = ea & W29_MASK;
         xl.attr     = ust_pkg::UST_ATTR_UNCACH;
      end else if (in_cached_low_kernel_window) begin
         xl.addr_err = !is_priv;
         xl.bypass   = is_priv;
         xl.paddr    = ea & W29_MASK;
         xl.attr     = kernel_window_cache_attr;
      end else if (in_xphys) begin
         if (!is_priv || !kernel_wide_addr_enable ||
             xphys_hi_err) begin
            xl.addr_err = 1'b1;
         end else begin
            xl.bypass = 1'b1;
            xl.paddr  = ea & PA_MASK;
            // Selector bits give encodings 0..7 in order
            xl.attr   = ea[ust_pkg::UST_ATTR_MSB:
                           ust_pkg::UST_ATTR_LSB];
         end
      end else if (in_kuseg && is_priv && error_level_bit) begin
         xl.bypass = 1'b1;
         xl.attr   = ust_pkg::UST_ATTR_UNCACH;
         if (ERL_KEEP_HI) begin
            xl.paddr = ea & W31_MASK;
         end else begin
            xl.paddr = ea & W29_MASK;
         end
      end else if (in_xkuseg && !user_wide_addr_enable) begin
         xl.addr_err = 1'b1;
      end else if (in_xkuseg && ERL_WIDE && is_priv &&
                   error_level_bit) begin
         xl.bypass = 1'b1;
         xl.attr   = ust_pkg::UST_ATTR_UNCACH;
         xl.paddr  = ea & PA_MASK;
      end else if (is_user && !debug_mode_flag && !in_kuseg &&
                   !in_xkuseg) begin
         xl.addr_err = 1'b1;
      end else begin
         // Mapped: left for the TLB, effective address passed on
         xl.paddr = ea;
      end
   end

   // ==========================================================
   // Answer register
   // ==========================================================
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rsp_valid_q <= 1'b0;
      end else begin
         rsp_valid_q <= req_valid_i;
      end
   end

   // All answer fields launch from one edge
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rsp_q <= '0;
      end else if (req_valid_i) begin
         rsp_q <= xl;
      end
   end

   assign rsp_valid_o = rsp_valid_q;
   assign rsp_o       = rsp_q;

   // ==========================================================
   // Interrupt events
   // ==========================================================
   logic [ust_pkg::UST_EV_W-1:0] ev;
   logic [ust_pkg::UST_EV_W-1:0] w1c;
   logic                         bus_req;
   logic                         bus_wr;

   assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
   assign bus_wr  = bus_req && wb_we_i;

   assign ev[ust_pkg::UST_EV_ERR]   = rsp_valid_q && rsp_q.addr_err;
   assign ev[ust_pkg::UST_EV_PROBE] = rsp_valid_q && rsp_q.probe;
   assign ev[ust_pkg::UST_EV_XPHYS] = rsp_valid_q && rsp_q.bypass &&
                                      !rsp_q.probe;

   assign w1c = (bus_wr && wb_sel_i[0] &&
                 wb_adr_i == ust_pkg::UST_REG_IRQ_ST) ?
                wb_dat_i[ust_pkg::UST_EV_W-1:0] :
                {ust_pkg::UST_EV_W{1'b0}};

   // A new event wins over a same-cycle clear
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         irq_st_q <= ust_pkg::UST_IRQ_RST;
      end else begin
         irq_st_q <= (irq_st_q & ~w1c) | ev;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         irq_msk_q <= ust_pkg::UST_IRQ_RST;
      end else if (bus_wr && wb_sel_i[0] &&
                   wb_adr_i == ust_pkg::UST_REG_IRQ_MSK) begin
         irq_msk_q <= wb_dat_i[ust_pkg::UST_EV_W-1:0];
      end
   end

   assign irq_o = |(irq_st_q & irq_msk_q);

   // ==========================================================
   // Wishbone slave
   // ==========================================================
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         cfg_q <= ust_pkg::UST_CFG_RST;
      end else if (bus_wr && wb_sel_i[0] &&
                   wb_adr_i == ust_pkg::UST_REG_CFG) begin
         cfg_q <= wb_dat_i[ust_pkg::UST_CFG_W-1:0];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= bus_req;
      end
   end

   logic [31:0] rd_d;

   always_comb begin
      rd_d = 32'h0000_0000;
      if (wb_adr_i == ust_pkg::UST_REG_CFG) begin
         rd_d[ust_pkg::UST_CFG_W-1:0] = cfg_q;
      end else if (wb_adr_i == ust_pkg::UST_REG_IRQ_ST) begin
         rd_d[ust_pkg::UST_EV_W-1:0] = irq_st_q;
      end else if (wb_adr_i == ust_pkg::UST_REG_IRQ_MSK) begin
         rd_d[ust_pkg::UST_EV_W-1:0] = irq_msk_q;
      end else if (wb_adr_i == ust_pkg::UST_REG_PA_LO) begin
         rd_d = rsp_q.paddr[31:0];
      end else if (wb_adr_i == ust_pkg::UST_REG_PA_HI) begin
         rd_d = rsp_q.paddr[63:32];
      end else if (wb_adr_i == ust_pkg::UST_REG_INFO) begin
         rd_d[5:0] = {rsp_q.probe, rsp_q.bypass,
                      rsp_q.addr_err, rsp_q.attr};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         dat_q <= 32'h0000_0000;
      end else if (bus_req && !wb_we_i) begin
         dat_q <= rd_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

endmodule : ust_translate

/* File: sim/ust_translate_assertions.sv */
`timescale 1ns/1ps
module ust_translate_assertions #(
   parameter int PA_W = 36
) (
   input wire logic               ref_clk_i,
   input wire logic               rst_n_i,
   input wire logic               req_valid_i,
   input wire ust_pkg::ust_req_t  req_i,
   input wire logic               rsp_valid_o,
   input wire ust_pkg::ust_resp_t rsp_o,
   input wire logic               wb_cyc_i,
   input wire logic               wb_stb_i,
   input wire logic               wb_ack_o
);
   localparam logic [63:0] PA_M = (64'h1 << PA_W) - 64'h1;
   logic        kern;
   logic [63:0] va;
   assign va   = req_i.vaddr;
   assign kern = req_valid_i && req_i.mode == ust_pkg::UST_MODE_KERNEL;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // ==========================================================
   // Translation port and Wishbone acknowledge
   // ==========================================================
   a_rsp_follows: assert property (req_valid_i |=> rsp_valid_o)
      else $error("answer missing after request");
   a_rsp_no_extra: assert property (!req_valid_i |=> !rsp_valid_o)
      else $error("answer without request");
   a_rsp_stands: assert property (!req_valid_i |=> $stable(rsp_o))
      else $error("answer changed without request");
   a_uncached_low_kernel_window_map: assert property (kern &&
      va[63:29] == ust_pkg::UST_UNCACHED_LOW_KERNEL_WINDOW_BASE[63:29] |=> rsp_o.bypass &&
      !rsp_o.addr_err && rsp_o.attr == ust_pkg::UST_ATTR_UNCACH &&
      rsp_o.paddr == {35'h0, $past(va[28:0])})
      else $error("uncached window mapped wrongly");
   a_cached_low_kernel_window_map: assert property (kern &&
      va[63:29] == ust_pkg::UST_CACHED_LOW_KERNEL_WINDOW_BASE[63:29] |=> rsp_o.bypass &&
      !rsp_o.addr_err && rsp_o.paddr == {35'h0, $past(va[28:0])})
      else $error("cached window mapped wrongly");
   a_xphys_range: assert property (kern && va[63:62] == 2'h2 &&
      (va[58:0] >> PA_W) != 59'h0 |=> rsp_o.addr_err)
      else $error("wide physical window range not refused");
   a_xphys_map: assert property (kern && va[63:62] == 2'h2
      |=> rsp_o.addr_err || (rsp_o.bypass && rsp_o.attr == $past(va[61:59])
      && rsp_o.paddr == ($past(va) & PA_M)))
      else $error("wide physical window mapped wrongly");
   a_probe_exact: assert property (req_valid_i &&
      (va < ust_pkg::UST_PROBE_LO || va > ust_pkg::UST_PROBE_HI)
      |=> !rsp_o.probe)
      else $error("probe flag outside probe range");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o)
      else $error("bus request not answered");
   c_probe: cover property (rsp_valid_o && rsp_o.probe);
   c_err: cover property (rsp_valid_o && rsp_o.addr_err);
   c_bypass: cover property (rsp_valid_o && rsp_o.bypass);
endmodule : ust_translate_assertions

bind ust_translate ust_translate_assertions #(.PA_W(PA_W))
   i_ust_translate_assertions (.ref_clk_i, .rst_n_i, .req_valid_i, .req_i,
   .rsp_valid_o, .rsp_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

/* File: sim/ust_partner.sv */
`timescale 1ns/1ps
module ust_partner (
   input  wire logic               ref_clk_i,
   input  wire logic               rsp_valid_i,
   input  wire ust_pkg::ust_resp_t rsp_i,
   output logic                    req_valid_o,
   output ust_pkg::ust_req_t       req_o
);
   initial begin
      req_valid_o = 1'b0;
      req_o = '0;
   end
   // Random idle gap, one-cycle strobe, bounded wait for answer
   task automatic send(input ust_pkg::ust_req_t r,
      output ust_pkg::ust_resp_t a, output bit ok);
      int n;
      n = 0;
      repeat ($urandom % 3) @(posedge ref_clk_i);
      req_valid_o <= 1'b1;
      req_o <= r;
      @(posedge ref_clk_i);
      req_valid_o <= 1'b0;
      req_o <= ~r;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (rsp_valid_i !== 1'b1 && n < 8);
      ok = rsp_valid_i === 1'b1 && n == 1;
      a = rsp_i;
   endtask : send
endmodule : ust_partner

/* File: sim/tb_ust_translate.sv */
`timescale 1ns/1ps
module tb_ust_translate;
   localparam int          PA_W = 36;
   localparam int          SEG_W = 40;
   localparam logic [63:0] PA_M = (64'h1 << PA_W) - 64'h1;
   logic ref_clk_i, rst_n_i, req_valid_i, rsp_valid_o, wb_ack_o, irq_o;
   logic wb_cyc_i, wb_stb_i, wb_we_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [6:0] cfg;
   logic [63:0] last, v, rv;
   ust_pkg::ust_req_t  req_i;
   ust_pkg::ust_resp_t rsp_o;
   int fail_count, cmp_count;
   ust_translate #(.PA_W(PA_W)) i_ust_translate (.ref_clk_i, .rst_n_i,
      .req_valid_i, .req_i, .rsp_valid_o, .rsp_o, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .irq_o);
   ust_partner i_ust_partner (.ref_clk_i, .rsp_valid_i(rsp_valid_o),
      .rsp_i(rsp_o), .req_valid_o(req_valid_i), .req_o(req_i));
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [63:0] e, g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wb(input bit we, input logic [7:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, ad, d};
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         fail_count++;
         $display("mismatch wb_ack expected 1 seen %b", wb_ack_o);
      end
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
      @(posedge ref_clk_i);
   endtask : wb
   task automatic setcfg(input logic [6:0] c);
      wb(1, ust_pkg::UST_REG_CFG, {25'h0, c});
      cfg = c;
   endtask : setcfg
   // ==========================================================
   // Reference translation; level says which fields are defined
   // ==========================================================
   function automatic int model(input logic [63:0] v, input int md,
      input bit f, input logic [6:0] c, output ust_pkg::ust_resp_t e);
      bit pr;
      bit xk;
      pr = md == 2 || c[6];
      e = '0;
      if (md == 0 && !c[6] && !c[4] && !f) v = {{32{v[31]}}, v[31:0]};
      e.paddr = v;
      if (v[63:29] == {35{1'b1}}) begin
         e.probe = c[6] && v >= ust_pkg::UST_PROBE_LO && v <= ust_pkg::UST_PROBE_HI;
         return e.probe ? 3 : ((pr || md == 1) ? 1 : 0);
      end
      e.bypass = 1'b1;
      e.attr = ust_pkg::UST_ATTR_UNCACH;
      if (v[63:30] == ust_pkg::UST_CACHED_LOW_KERNEL_WINDOW_BASE[63:30]) begin
         e.paddr = {35'h0, v[28:0]};
         if (!v[29]) e.attr = c[2:0];
         return pr ? 2 : 0;
      end
      if (v[63:62] == 2'h2) begin
         e.paddr = v & PA_M;
         e.attr = v[61:59];
         return (!pr || !c[5] || (v[58:0] >> PA_W) != 0) ? 0 : 2;
      end
      xk = v[63:31] != 0 && (v >> SEG_W) == 0;
      e.bypass = pr && c[3] && (v[63:31] == 0 || (xk && c[4]));
      if (e.bypass) e.paddr = v & PA_M;
      if (xk && !c[4]) return 0;
      if (md == 0 && !pr && v[63:31] != 0 && !xk) return 0;
      return e.bypass ? 2 : 1;
   endfunction : model
   task automatic xl(input logic [63:0] v, input int md, input bit f);
      ust_pkg::ust_req_t  r;
      ust_pkg::ust_resp_t a, e;
      bit ok;
      int l;
      r = {v, ust_pkg::ust_mode_t'(md), f};
      l = model(v, md, f, cfg, e);
      i_ust_partner.send(r, a, ok);
      chk("rsp_valid", 1, ok);
      if (l < 4) chk("probe", e.probe, a.probe);
      if (l < 3) chk("addr_err", l == 0, a.addr_err);
      if (l == 1 || l == 2) chk("bypass", e.bypass, a.bypass);
      if (l == 1 || l == 2) chk("paddr", e.paddr, a.paddr);
      if (l == 2) chk("attr", e.attr, a.attr);
      last = e.paddr;
   endtask : xl
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      fail_count++;
      end_sim();
   end
   initial begin
      {rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      wb_sel_i = 4'hF;
      void'($urandom(58));
      repeat (16) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      foreach (q[i]) if (i < 4) begin
         wb(0, 8'(4 * i), 32'h0);
         chk("reset_reg", i == 0 ? 32'h3 : 32'h0, q);
      end
      wb(0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, q);
      $display("test registers done");
      setcfg(7'h25);
      foreach (rv[i]) if (i < 3) xl(64'hFFFF_FFFF_A000_0000 - (i << 29), 2, 0);
      xl(64'hFFFF_FFFF_9FFF_FFFF, 2, 0);
      wb(0, ust_pkg::UST_REG_PA_LO, 32'h0);
      chk("pa_lo", last[31:0], q);
      xl(64'hFFFF_FFFF_A000_0000, 1, 0);
      for (int k = 0; k < 8; k++) xl({2'h2, 3'(k), 59'h0} | PA_M, 2, 0);
      xl(64'h8000_0010_0000_0000, 2, 0);
      xl(64'h8400_0000_0000_0000, 2, 0);
      setcfg(7'h05);
      xl(64'h9000_0000_0000_1000, 2, 0);
      $display("test kernel windows done");
      setcfg(7'h38);
      xl(64'h7FFF_FFFF, 2, 0);
      xl(64'hFF_0000_1000, 2, 0);
      setcfg(7'h08);
      xl(64'hFF_0000_1000, 2, 0);
      setcfg(7'h00);
      xl(64'h1_7FFF_FFFC, 0, 0);
      xl(64'h1_7FFF_FFFC, 0, 1);
      xl(64'h8000_0000, 0, 0);
      xl(ust_pkg::UST_PROBE_LO, 2, 0);
      setcfg(7'h40);
      foreach (rv[i]) if (i < 2) xl(ust_pkg::UST_PROBE_LO + i, 0, 0);
      xl(ust_pkg::UST_PROBE_LO - 1, 2, 0);
      xl(ust_pkg::UST_PROBE_HI + 1, 2, 0);
      xl(ust_pkg::UST_PROBE_HI, 2, 0);
      $display("test special modes done");
      setcfg(7'h02);
      wb(1, ust_pkg::UST_REG_IRQ_ST, 32'h7);
      xl(64'hFFFF_FFFF_A000_0000, 2, 0);
      wb(0, ust_pkg::UST_REG_IRQ_ST, 32'h0);
      chk("irq_st", 32'h4, q);
      wb(1, ust_pkg::UST_REG_IRQ_MSK, 32'h4);
      chk("irq_on", 1, irq_o);
      wb(1, ust_pkg::UST_REG_IRQ_MSK, 32'h1);
      chk("irq_masked", 0, irq_o);
      xl(64'hFFFF_FFFF_8000_0000, 0, 0);
      @(posedge ref_clk_i);
      chk("irq_err", 1, irq_o);
      wb(1, ust_pkg::UST_REG_IRQ_ST, 32'h7);
      chk("irq_clr", 0, irq_o);
      $display("test interrupts done");
      for (int i = 0; i < 96; i++) begin
         if (i % 12 == 0) setcfg(7'($urandom));
         rv = {$urandom, $urandom};
         case ($urandom % 5)
            0: v = 64'hFFFF_FFFF_8000_0000 | rv[29:0];
            1: v = {2'h2, rv[61:0]} & (rv[0] ? 64'hF800_000F_FFFF_FFFF : '1);
            2: v = rv & 64'h7FFF_FFFF;
            3: v = (rv & 64'hFF_7FFF_FFFF) | 64'h1_0000_0000;
            default: v = 64'hFFFF_FFFF_FF00_0000 | rv[22:0];
         endcase
         xl(v, $urandom % 3, rv[63]);
      end
      $display("test random done");
      end_sim();
   end
endmodule : tb_ust_translate
